// ### inc/occ_map.svh
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH

// Register byte offsets on the APB bus.
`define OCC_CTRL_OFS 12'h000
`define OCC_PRI_OFS 12'h004
`define OCC_SEC_OFS 12'h008

// Control register field positions.
`define OCC_IDLE_BIT 13
`define OCC_FAULT_BIT 4
`define OCC_TSEL_BIT 3
`define OCC_MODE_HI 2
`define OCC_MODE_LO 0

// Reset values.
`define OCC_CTRL_RST 16'h0000
`define OCC_CMP_RST 16'h0000

// Channels numbered up to this value answer to the first fault input.
`define OCC_FAULT_A_LAST 4

`endif

// ### inc/occ_pkg.sv
`include "occ_map.svh"

package occ_pkg;

  // Operating modes as held in the mode field.
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_LOW_SET = 3'h1,
    MODE_HIGH_CLR = 3'h2,
    MODE_TOGGLE = 3'h3,
    MODE_ONE_PULSE = 3'h4,
    MODE_PULSE_TRAIN = 3'h5,
    MODE_PWM = 3'h6,
    MODE_PWM_FAULT = 3'h7
  } mode_type;

  // Progress of a delayed or continuous pulse.
  typedef enum logic [1:0] {
    PULSE_RISE,
    PULSE_FALL,
    PULSE_DONE
  } pulse_state_type;

endpackage

// ### rtl/level_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two flip-flop synchroniser for one pin level.
module level_sync (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Pin level and its synchronised copy.
  input wire logic async_in,
  output logic sync_out
);

  // First stage, read only by the second stage.
  logic meta_q;

  // Both stages reset high, the idle level of an active-low fault pin.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ### rtl/duty_shadow.sv
`timescale 1ns/1ps
`default_nettype none
`include "occ_map.svh"

// Working copies of the compare values that the match logic uses.
module duty_shadow (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control.
  input wire logic pwm_in,
  input wire logic load_in,
  // Software values.
  input wire logic [15:0] pri_in,
  input wire logic [15:0] sec_in,
  // Working values.
  output logic [15:0] act_pri_out,
  output logic [15:0] act_sec_out
);

  // In PWM modes the copies move only at a period boundary, so a duty
  // written mid-period never cuts the running pulse short. Elsewhere they
  // follow software with one cycle of lag.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      act_pri_out <= `OCC_CMP_RST;
      act_sec_out <= `OCC_CMP_RST;
    end else if (!pwm_in || load_in) begin
      act_pri_out <= pri_in;
      act_sec_out <= sec_in;
    end
  end

endmodule

`default_nettype wire

// ### rtl/compare_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "occ_map.svh"

// Function
// - Timer-select bit one picks second timer.
// - Compare timer against one or two values.
// - Mode comes from control bits two-zero.
// - Mode 000: disabled, pin under port.
// - Mode 001: start low, match sets high.
// - Mode 010: start high, match clears low.
// - Mode 011: keep level, match toggles.
// - Toggle mode interrupts on both edges.
// - Mode 100: one pulse, interrupt falling.
// - Mode 101: repeating pulses, interrupt falling.
// - PWM starts high unless primary is zero.
// - Mode 110: PWM, no fault, no interrupt.
// - Mode 111: PWM, fault falling edge interrupts.
// - Fault A serves 1-4, B 5-8.
// - Fault flag read-only, cleared by hardware.
// - Idle-stop bit halts channel in idle.
// - Unimplemented control bits read zero.
module compare_channel #(
  parameter int CHANNEL_NUMBER = 1
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Time bases and processor state.
  input wire logic [15:0] timer2_count_in,
  input wire logic [15:0] timer3_count_in,
  input wire logic cpu_idle_in,
  // General-purpose port values used while disabled.
  input wire logic gpio_level_in,
  input wire logic gpio_enable_in,
  // Fault pins, active low.
  input wire logic fault_input_a_in,
  input wire logic fault_input_b_in,
  // Output pin and interrupt.
  output logic compare_output_pin_out,
  output logic compare_output_oe_out,
  output logic compare_irq_out
);

  import occ_pkg::*;

  // True when an APB address selects the register at the given offset.
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // True when a fresh timer step lands on a compare value.
  function automatic logic compare_hit(input logic step, input logic [15:0] t, input logic [15:0] v);
    compare_hit = step && (t == v);
  endfunction

  // Control fields.
  logic idle_stop_control_q;
  logic time_base_select_q;
  mode_type compare_mode_field_q;
  logic fault_status_flag_q;
  // Software compare values.
  logic [15:0] primary_compare_value_q;
  logic [15:0] secondary_compare_value_q;
  // Working compare values.
  logic [15:0] act_pri;
  logic [15:0] act_sec;
  // Bus handshake registers.
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  // Timer view.
  logic [15:0] timer_now;
  logic [15:0] timer_prev_q;
  logic count_step;
  logic boundary;
  // Mode tracking.
  mode_type mode_seen_q;
  logic entry;
  logic run;
  logic pwm_mode;
  // Matches and pulse progress.
  logic match_pri;
  logic match_sec;
  pulse_state_type pulse_q;
  logic pulse_rise;
  logic pulse_fall;
  // Fault pins.
  logic fault_a_s;
  logic fault_b_s;
  logic fault_sel;
  logic fault_prev_q;
  logic fault_fall;
  // Pin and interrupt registers.
  logic pin_q;
  logic oe_q;
  logic irq_q;
  // Bus strobes.
  logic bus_wr;
  logic bus_setup;
  logic addr_ok;

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign compare_output_pin_out = pin_q;
  assign compare_output_oe_out = oe_q;
  assign compare_irq_out = irq_q;

  // Decode shared by the read and write paths.
  assign addr_ok = reg_hit(paddr_in, `OCC_CTRL_OFS) || reg_hit(paddr_in, `OCC_PRI_OFS)
                   || reg_hit(paddr_in, `OCC_SEC_OFS);
  assign bus_setup = psel_in && !penable_in;
  // A write lands only at the edge that completes the access phase.
  assign bus_wr = psel_in && penable_in && pready_q && pwrite_in;

  // Ready rises in the first access cycle, so every transfer has no wait.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= bus_setup;
      pslverr_q <= bus_setup && !addr_ok;
    end
  end

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (bus_setup) begin
      prdata_q <= 32'h0000_0000;
      if (reg_hit(paddr_in, `OCC_CTRL_OFS)) begin
        // Unimplemented bits stay zero in this word.
        prdata_q[`OCC_IDLE_BIT] <= idle_stop_control_q;
        prdata_q[`OCC_FAULT_BIT] <= fault_status_flag_q;
        prdata_q[`OCC_TSEL_BIT] <= time_base_select_q;
        prdata_q[`OCC_MODE_HI:`OCC_MODE_LO] <= compare_mode_field_q;
      end else if (reg_hit(paddr_in, `OCC_PRI_OFS)) begin
        prdata_q[15:0] <= primary_compare_value_q;
      end else if (reg_hit(paddr_in, `OCC_SEC_OFS)) begin
        prdata_q[15:0] <= secondary_compare_value_q;
      end
    end
  end

  // Control register writes. The fault flag is not writable here. The
  // hardware does not guard against a write while the timer runs, so a
  // mode change mid-count may produce a stray edge.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_stop_control_q <= 1'(`OCC_CTRL_RST >> `OCC_IDLE_BIT);
      time_base_select_q <= 1'(`OCC_CTRL_RST >> `OCC_TSEL_BIT);
      compare_mode_field_q <= MODE_OFF;
    end else if (bus_wr && reg_hit(paddr_in, `OCC_CTRL_OFS)) begin
      idle_stop_control_q <= pwdata_in[`OCC_IDLE_BIT];
      time_base_select_q <= pwdata_in[`OCC_TSEL_BIT];
      compare_mode_field_q <= mode_type'(pwdata_in[`OCC_MODE_HI:`OCC_MODE_LO]);
    end
  end

  // Compare value writes.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      primary_compare_value_q <= `OCC_CMP_RST;
      secondary_compare_value_q <= `OCC_CMP_RST;
    end else if (bus_wr) begin
      if (reg_hit(paddr_in, `OCC_PRI_OFS)) begin
        primary_compare_value_q <= pwdata_in[15:0];
      end
      if (reg_hit(paddr_in, `OCC_SEC_OFS)) begin
        secondary_compare_value_q <= pwdata_in[15:0];
      end
    end
  end

  // Time base selection and step detection. A prescaled timer holds its
  // count for many cycles; only the cycle in which it moves may match.
  assign timer_now = time_base_select_q ? timer3_count_in : timer2_count_in;
  assign count_step = (timer_now != timer_prev_q);
  assign boundary = count_step && (timer_now == 16'h0000);

  // Previous timer count.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_prev_q <= 16'h0000;
    end else begin
      timer_prev_q <= timer_now;
    end
  end

  // Mode entry is the first cycle in which a new mode is seen.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_seen_q <= MODE_OFF;
    end else begin
      mode_seen_q <= compare_mode_field_q;
    end
  end

  assign entry = (compare_mode_field_q != mode_seen_q);
  assign pwm_mode = (compare_mode_field_q == MODE_PWM) || (compare_mode_field_q == MODE_PWM_FAULT);
  // The channel acts only when enabled and not parked by idle.
  assign run = (compare_mode_field_q != MODE_OFF)
               && !(idle_stop_control_q && cpu_idle_in);

  // Working copies of the compare values.
  duty_shadow u_shadow (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pwm_in(pwm_mode),
    .load_in(boundary),
    .pri_in(primary_compare_value_q),
    .sec_in(secondary_compare_value_q),
    .act_pri_out(act_pri),
    .act_sec_out(act_sec)
  );

  // Pulse modes use both values, the others the primary alone.
  assign match_pri = compare_hit(count_step, timer_now, act_pri);
  assign match_sec = compare_hit(count_step, timer_now, act_sec);

  // Fault pins pass two flip-flops before any logic reads them.
  level_sync u_sync_a (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in(fault_input_a_in),
    .sync_out(fault_a_s)
  );

  level_sync u_sync_b (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in(fault_input_b_in),
    .sync_out(fault_b_s)
  );

  // The channel number picks which fault pin governs it.
  assign fault_sel = (CHANNEL_NUMBER <= `OCC_FAULT_A_LAST) ? fault_a_s : fault_b_s;

  // Previous synchronised fault level, for edge detection.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_prev_q <= 1'b1;
    end else begin
      fault_prev_q <= fault_sel;
    end
  end

  assign fault_fall = fault_prev_q && !fault_sel;

  // Fault flag: set by a falling fault edge in mode 111, cleared by
  // hardware at a period boundary once the pin is high again, or when the
  // mode is left. A set in the same cycle as a clear wins.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_status_flag_q <= 1'b0;
    end else if (run && compare_mode_field_q == MODE_PWM_FAULT && fault_fall) begin
      fault_status_flag_q <= 1'b1;
    end else if (compare_mode_field_q != MODE_PWM_FAULT || (boundary && fault_sel)) begin
      fault_status_flag_q <= 1'b0;
    end
  end

  // Pulse sequencer for delayed one-shot and continuous pulse modes.
  assign pulse_rise = run && !entry && pulse_q == PULSE_RISE && match_pri;
  assign pulse_fall = run && !entry && pulse_q == PULSE_FALL && match_sec;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pulse_q <= PULSE_RISE;
    end else if (entry) begin
      pulse_q <= PULSE_RISE;
    end else begin
      case (pulse_q)
        PULSE_RISE: begin
          if (pulse_rise) begin
            pulse_q <= PULSE_FALL;
          end
        end
        PULSE_FALL: begin
          // Continuous mode rearms; the single pulse mode stops.
          if (pulse_fall) begin
            pulse_q <= (compare_mode_field_q == MODE_PULSE_TRAIN) ? PULSE_RISE : PULSE_DONE;
          end
        end
        PULSE_DONE: begin
          pulse_q <= PULSE_DONE;
        end
        default: begin
          pulse_q <= PULSE_RISE;
        end
      endcase
    end
  end

  // Output pin level and drive enable.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (compare_mode_field_q == MODE_OFF) begin
      // The port logic owns the pin.
      pin_q <= gpio_level_in;
      oe_q <= gpio_enable_in;
    end else if (entry) begin
      oe_q <= 1'b1;
      case (compare_mode_field_q)
        MODE_LOW_SET: pin_q <= 1'b0;
        MODE_HIGH_CLR: pin_q <= 1'b1;
        MODE_TOGGLE: pin_q <= pin_q;
        MODE_ONE_PULSE: pin_q <= 1'b0;
        MODE_PULSE_TRAIN: pin_q <= 1'b0;
        MODE_PWM: pin_q <= (primary_compare_value_q != 16'h0000);
        MODE_PWM_FAULT: pin_q <= (primary_compare_value_q != 16'h0000);
        default: pin_q <= 1'b0;
      endcase
    end else if (run) begin
      case (compare_mode_field_q)
        MODE_LOW_SET: begin
          if (match_pri) begin
            pin_q <= 1'b1;
          end
        end
        MODE_HIGH_CLR: begin
          if (match_pri) begin
            pin_q <= 1'b0;
          end
        end
        MODE_TOGGLE: begin
          if (match_pri) begin
            pin_q <= !pin_q;
          end
        end
        MODE_ONE_PULSE, MODE_PULSE_TRAIN: begin
          if (pulse_rise) begin
            pin_q <= 1'b1;
          end else if (pulse_fall) begin
            pin_q <= 1'b0;
          end
        end
        MODE_PWM, MODE_PWM_FAULT: begin
          // A fault floats the pin until the flag clears at a boundary.
          if (compare_mode_field_q == MODE_PWM_FAULT && (fault_status_flag_q || fault_fall)) begin
            oe_q <= 1'b0;
          end else begin
            oe_q <= 1'b1;
            if (boundary) begin
              pin_q <= (primary_compare_value_q != 16'h0000);
            end else if (match_pri) begin
              pin_q <= 1'b0;
            end
          end
        end
        default: begin
          pin_q <= pin_q;
        end
      endcase
    end
  end

  // Interrupt pulse, one cycle per event. Mode 110 never raises one.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_q <= 1'b0;
    end else if (!run || entry) begin
      irq_q <= 1'b0;
    end else begin
      case (compare_mode_field_q)
        MODE_LOW_SET, MODE_HIGH_CLR: irq_q <= match_pri;
        MODE_TOGGLE: irq_q <= match_pri;
        MODE_ONE_PULSE, MODE_PULSE_TRAIN: irq_q <= pulse_fall;
        MODE_PWM_FAULT: irq_q <= fault_fall;
        default: irq_q <= 1'b0;
      endcase
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_timer3_select:
    assert property (time_base_select_q && count_step && timer3_count_in == act_pri |-> match_pri)
    else $error("second timer count did not match");

  a_off_follows_port:
    assert property (compare_mode_field_q == MODE_OFF |=> compare_output_pin_out == $past(gpio_level_in))
    else $error("disabled channel does not follow port level");

  a_low_entry:
    assert property (entry && compare_mode_field_q == MODE_LOW_SET |=> !compare_output_pin_out)
    else $error("mode 001 did not start low");

  a_high_entry:
    assert property (entry && compare_mode_field_q == MODE_HIGH_CLR |=> compare_output_pin_out)
    else $error("mode 010 did not start high");

  a_toggle_flip:
    assert property (run && !entry && compare_mode_field_q == MODE_TOGGLE && match_pri
                     |=> compare_output_pin_out != $past(compare_output_pin_out) && compare_irq_out)
    else $error("toggle match did not flip pin with interrupt");

  a_pwm_start:
    assert property (entry && pwm_mode |=> compare_output_pin_out == ($past(primary_compare_value_q) != 16'h0000))
    else $error("PWM start level wrong");

  a_pwm_quiet:
    assert property (compare_mode_field_q == MODE_PWM |=> !compare_irq_out)
    else $error("mode 110 raised an interrupt");

  a_fault_flag:
    assert property (run && !entry && compare_mode_field_q == MODE_PWM_FAULT && fault_fall
                     |=> fault_status_flag_q && compare_irq_out ##1 !compare_output_oe_out)
    else $error("fault did not set flag, interrupt and float the pin");

  a_idle_halt:
    assert property (compare_mode_field_q != MODE_OFF && !entry && idle_stop_control_q && cpu_idle_in
                     |=> $stable(compare_output_pin_out) && !compare_irq_out)
    else $error("channel moved while halted in idle");

  a_unused_zero:
    assert property (pready_out && paddr_in == `OCC_CTRL_OFS
                     |-> prdata_out[15:14] == 2'h0 && prdata_out[12:5] == 8'h00)
    else $error("unimplemented control bits not zero");

endmodule

`default_nettype wire

// ### tb/occ_far_side.sv
`timescale 1ns/1ps
`default_nettype none

// Board circuit at the channel's pins: a pin with a pull-down and two fault lines.
module occ_far_side (
  // Clock.
  input wire logic clk_in,
  // Channel pin and its drive enable.
  input wire logic pin_in,
  input wire logic oe_in,
  // Bench requests to pull a fault line low.
  input wire logic fault_a_req_in,
  input wire logic fault_b_req_in,
  // Resolved pin level and the fault lines.
  output logic pin_level_out,
  output logic fault_input_a_out,
  output logic fault_input_b_out
);
  // The pull-down wins whenever the channel floats the pin, so a float reads low.
  assign pin_level_out = oe_in ? pin_in : 1'b0;

  // Pull-ups hold both fault lines high until a fault is requested.
  initial begin
    fault_input_a_out = 1'b1;
    fault_input_b_out = 1'b1;
  end

  // Faults are active low and change just after a clock edge.
  always @(posedge clk_in) begin
    fault_input_a_out <= ~fault_a_req_in;
    fault_input_b_out <= ~fault_b_req_in;
  end
endmodule

`default_nettype wire

// ### tb/output_compare_channel_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "occ_map.svh"

// Self-checking bench for channel one with a table of compare modes.
module output_compare_channel_tb;
  localparam int PER = 32; // Timer period; the count wraps to zero here.
  typedef struct {logic err; logic rd; logic [31:0] data;} note_type;
  typedef struct {logic [15:0] ctrl; logic [15:0] pri; logic idle; logic e; logic m; logic f; int irqs;} row_type;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [15:0] t2 = 16'h0000;
  logic [15:0] t3 = 16'h0000;
  logic run2 = 1'b0;
  logic run3 = 1'b0;
  logic cpu_idle = 1'b0;
  logic gpio_lvl = 1'b0;
  logic gpio_en = 1'b0;
  logic fa_req = 1'b0;
  logic fb_req = 1'b0;
  logic fault_a;
  logic fault_b;
  logic pin_out;
  logic oe_out;
  logic irq_out;
  logic pin_level;
  int seed = 9731;
  int miscompares = 0;
  int num_checks = 0;
  int irq_cnt = 0;
  int base;
  logic [31:0] rnd;
  note_type exp_q[$];
  note_type mon_n;
  // Columns: control, primary, idle, entry, mid-run and final pin, interrupt count.
  row_type rows[10] = '{
    '{16'h0001, 16'h000A, 1'b0, 1'b0, 1'b1, 1'b1, 2},
    '{16'h000A, 16'h000A, 1'b0, 1'b1, 1'b0, 1'b0, 2},
    '{16'h0003, 16'h000A, 1'b0, 1'b0, 1'b1, 1'b0, 2},
    '{16'h200B, 16'h000A, 1'b1, 1'b0, 1'b0, 1'b0, 0},
    '{16'h000B, 16'h000A, 1'b1, 1'b0, 1'b1, 1'b0, 2},
    '{16'h0004, 16'h000A, 1'b0, 1'b0, 1'b1, 1'b0, 1},
    '{16'h000D, 16'h000A, 1'b0, 1'b0, 1'b1, 1'b0, 2},
    '{16'h0006, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 0},
    '{16'h000E, 16'h000A, 1'b0, 1'b0, 1'b0, 1'b1, 0},
    '{16'h0007, 16'h000A, 1'b0, 1'b1, 1'b0, 1'b1, 0}};

  // Clock at 200 MHz.
  always #2.5 clk_in = ~clk_in;

  // Two free timers; each one only moves while the bench lets it run.
  always @(posedge clk_in) begin
    if (run2) t2 <= (t2 == PER - 1) ? 16'h0000 : t2 + 16'h0001;
    if (run3) t3 <= (t3 == PER - 1) ? 16'h0000 : t3 + 16'h0001;
    if (irq_out === 1'b1) irq_cnt <= irq_cnt + 1;
  end


  compare_channel #(.CHANNEL_NUMBER(1)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .timer2_count_in(t2), .timer3_count_in(t3), .cpu_idle_in(cpu_idle),
    .gpio_level_in(gpio_lvl), .gpio_enable_in(gpio_en),
    .fault_input_a_in(fault_a), .fault_input_b_in(fault_b),
    .compare_output_pin_out(pin_out), .compare_output_oe_out(oe_out), .compare_irq_out(irq_out));

  occ_far_side far_u (
    .clk_in(clk_in), .pin_in(pin_out), .oe_in(oe_out), .fault_a_req_in(fa_req), .fault_b_req_in(fb_req),
    .pin_level_out(pin_level), .fault_input_a_out(fault_a), .fault_input_b_out(fault_b));

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; the expected answer is queued before the request goes out.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ed,
                     input logic ee);
    int n;
    exp_q.push_back('{ee, ~wr, ed});
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    // Ready is sampled at the rising edge; the request stands until then.
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (n == 20) check(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Watches completed transfers and compares them with the oldest note.
  always @(negedge clk_in) begin
    if (psel && penable && pready_out === 1'b1 && exp_q.size() > 0) begin
      mon_n = exp_q.pop_front();
      check(pslverr_out, mon_n.err);
      if (mon_n.rd) check(prdata_out, mon_n.data);
    end
  end

  // Runs one table row: entry level, level mid-period, then the final level and interrupt count after two full periods.
  task automatic run_row(input row_type r);
    int i0;
    @(posedge clk_in);
    cpu_idle <= r.idle;
    apb(1'b1, `OCC_PRI_OFS, {16'h0000, r.pri}, 32'h0, 1'b0);
    apb(1'b1, `OCC_CTRL_OFS, {16'h0000, r.ctrl}, 32'h0, 1'b0);
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    check(pin_level, r.e);
    check(oe_out, 1'b1);
    i0 = irq_cnt;
    @(posedge clk_in);
    run2 <= ~r.ctrl[3];
    run3 <= r.ctrl[3];
    repeat (15) @(posedge clk_in);
    @(negedge clk_in);
    check(pin_level, r.m);
    repeat (2 * PER - 15) @(posedge clk_in);
    run2 <= 1'b0;
    run3 <= 1'b0;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    check(pin_level, r.f);
    check(irq_cnt - i0, r.irqs);
  endtask

  // Watchdog: the whole run needs well under this span.
  initial begin
    #100000;
    miscompares++;
    summarize();
  end

  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    apb(1'b0, `OCC_CTRL_OFS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, `OCC_PRI_OFS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, `OCC_SEC_OFS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h00C, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF, 32'h0, 1'b1);
    apb(1'b1, `OCC_CTRL_OFS, 32'hFFFF_FFFF, 32'h0, 1'b0);
    apb(1'b0, `OCC_CTRL_OFS, 32'h0, 32'h0000_200F, 1'b0);
    apb(1'b1, `OCC_CTRL_OFS, 32'h0, 32'h0, 1'b0);
    // Disabled channel hands the pin to the port; random levels reach it.
    repeat (4) begin
      @(posedge clk_in);
      rnd = $random(seed);
      gpio_lvl <= rnd[0];
      gpio_en <= rnd[1];
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      check(pin_out, rnd[0]);
      check(oe_out, rnd[1]);
    end
    rnd = $random(seed);
    apb(1'b1, `OCC_SEC_OFS, rnd, 32'h0, 1'b0);
    apb(1'b0, `OCC_SEC_OFS, 32'h0, {16'h0000, rnd[15:0]}, 1'b0);
    apb(1'b1, `OCC_SEC_OFS, 32'd20, 32'h0, 1'b0);
    foreach (rows[i]) run_row(rows[i]);
    // The second fault line does not govern channel one.
    @(posedge clk_in);
    base = irq_cnt;
    fb_req <= 1'b1;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    check(irq_cnt - base, 32'd0);
    check(oe_out, 1'b1);
    @(posedge clk_in);
    fb_req <= 1'b0;
    fa_req <= 1'b1;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    check(irq_cnt - base, 32'd1);
    check(oe_out, 1'b0);
    apb(1'b0, `OCC_CTRL_OFS, 32'h0, 32'h0000_0017, 1'b0);
    apb(1'b1, `OCC_CTRL_OFS, 32'h0000_0007, 32'h0, 1'b0);
    apb(1'b0, `OCC_CTRL_OFS, 32'h0, 32'h0000_0017, 1'b0);
    // Flag clears only at a period boundary once the fault line is high again.
    fa_req <= 1'b0;
    repeat (4) @(posedge clk_in);
    run2 <= 1'b1;
    repeat (PER) @(posedge clk_in);
    run2 <= 1'b0;
    apb(1'b0, `OCC_CTRL_OFS, 32'h0, 32'h0000_0007, 1'b0);
    @(negedge clk_in);
    check(oe_out, 1'b1);
    // Plain PWM ignores the fault line altogether.
    apb(1'b1, `OCC_CTRL_OFS, 32'h0000_0006, 32'h0, 1'b0);
    base = irq_cnt;
    fa_req <= 1'b1;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    check(irq_cnt - base, 32'd0);
    check(oe_out, 1'b1);
    @(posedge clk_in);
    fa_req <= 1'b0;
    summarize();
  end
endmodule

`default_nettype wire
